// ===== logic/cdr_defines.vh
// register offsets, field positions and reset values of the ch7 slice
`ifndef CDR_DEFINES_VH
`define CDR_DEFINES_VH

`define CDR_ADDR_W           6
`define CDR_DATA_W           16
`define CDR_OFS_INT_FRAC_HI  6'h13
`define CDR_OFS_FRAC_LO      6'h14
`define CDR_OFS_STATUS       6'h15
`define CDR_INT_MSB          11
`define CDR_INT_LSB          4
`define CDR_FRAC_HI_MSB      3
`define CDR_FRAC_HI_LSB      0
`define CDR_STAT_UNLOCK      2
`define CDR_STAT_LOS         1
`define CDR_STAT_SEL         0
`define CDR_RST_INT_FRAC_HI  16'h0000
`define CDR_RST_FRAC_LO      16'h0000
`define CDR_ZERO16           16'h0000
`define CDR_ZERO8            8'h00
`define CDR_ONE9             9'h001
`define CDR_ZERO20           20'h00000
`define CDR_STAT_W           3
`define CDR_BIT_LOW          1'h0

`endif

// ===== logic/cdr_sync2.v
// two-flop synchroniser for status levels sampled from the pll domain
`timescale 1ns/1ps
module cdr_sync2 #(
   parameter WIDTH = 3
) (
   input  wire             clock,
   input  wire             arst_n,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ===== logic/cdr_ch7_regs.v
// channel 7 divider registers and pll status word
//
// Contract
// - channel 7 divides by integer field plus one
// - fraction bits 19-16 from integer register nibble
// - fraction bits 15-0 from following register
// - status bits 15-3 read zero, writes ignored
// - status bit 2 reads one while unlocked
// - lock pin high means locked
// - status bit 1 set while reference lost
// - status bit 0 shows secondary reference selected
// - fraction used only when its enable set
`timescale 1ns/1ps
`include "cdr_defines.vh"
module cdr_ch7_regs (
   input  wire                   clock,
   input  wire                   arst_n,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   input  wire [`CDR_ADDR_W-1:0] reg_addr,
   input  wire [`CDR_DATA_W-1:0] reg_wdata,
   input  wire                   ch7_fraction_enable,
   input  wire                   pll_unlocked,
   input  wire                   reference_lost_flag,
   input  wire                   ref_secondary,
   output reg  [`CDR_DATA_W-1:0] reg_rdata,
   output reg                    reg_rvalid,
   output reg  [8:0]             ch7_divide_ratio,
   output reg  [19:0]            ch7_fraction_setting,
   output reg                    ch7_fraction_active,
   output reg                    lock_pin
);

   //------------------------------------------------------------
   // register storage
   //------------------------------------------------------------
   reg  [`CDR_DATA_W-1:0] int_frac_hi_q;
   reg  [`CDR_DATA_W-1:0] int_frac_hi_d;
   reg  [`CDR_DATA_W-1:0] frac_lo_q;
   reg  [`CDR_DATA_W-1:0] frac_lo_d;
   reg  [`CDR_DATA_W-1:0] rdata_d;
   reg  [`CDR_DATA_W-1:0] rdata_hold_d;
   reg                    rvalid_d;
   reg  [8:0]             divide_ratio_d;
   reg  [19:0]            fraction_setting_d;
   reg                    fraction_active_d;
   reg                    lock_pin_d;
   wire [`CDR_DATA_W-1:0] status_word;
   wire [`CDR_STAT_W-1:0] stat_sync;
   wire [7:0]             ch7_integer_divider;
   wire [3:0]             frac_high_nibble;
   wire                   wr_int_frac_hi;
   wire                   wr_frac_lo;
   genvar                 g;

   //------------------------------------------------------------
   // write decode
   //------------------------------------------------------------
   // the status offset gets no write enable, so writes there vanish
   assign wr_int_frac_hi = reg_wr & (reg_addr == `CDR_OFS_INT_FRAC_HI);
   assign wr_frac_lo     = reg_wr & (reg_addr == `CDR_OFS_FRAC_LO);

   //------------------------------------------------------------
   // register next values
   //------------------------------------------------------------
   // top nibble stored as written; host keeps it zero
   always @* begin
      int_frac_hi_d = int_frac_hi_q;
      if (wr_int_frac_hi) begin
         int_frac_hi_d = reg_wdata;
      end
   end

   always @* begin
      frac_lo_d = frac_lo_q;
      if (wr_frac_lo) begin
         frac_lo_d = reg_wdata;
      end
   end

   //------------------------------------------------------------
   // register flops
   //------------------------------------------------------------
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         int_frac_hi_q <= `CDR_RST_INT_FRAC_HI;
      end else begin
         int_frac_hi_q <= int_frac_hi_d;
      end
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         frac_lo_q <= `CDR_RST_FRAC_LO;
      end else begin
         frac_lo_q <= frac_lo_d;
      end
   end

   //------------------------------------------------------------
   // divider fields
   //------------------------------------------------------------
   assign ch7_integer_divider =
      int_frac_hi_q[`CDR_INT_MSB:`CDR_INT_LSB];
   assign frac_high_nibble =
      int_frac_hi_q[`CDR_FRAC_HI_MSB:`CDR_FRAC_HI_LSB];

   //------------------------------------------------------------
   // status synchroniser
   //------------------------------------------------------------
   // levels only; a pulse shorter than one clock may be missed
   cdr_sync2 #(
      .WIDTH (`CDR_STAT_W)
   ) u_sync (
      .clock    (clock),
      .arst_n   (arst_n),
      .async_in ({pll_unlocked, reference_lost_flag, ref_secondary}),
      .sync_out (stat_sync)
   );

   //------------------------------------------------------------
   // status word, one slice per bit
   //------------------------------------------------------------
   generate
      for (g = 0; g < `CDR_DATA_W; g = g + 1) begin : g_stat
         if (g < `CDR_STAT_W) begin : g_live
            // live view; reading clears nothing
            assign status_word[g] = stat_sync[g];
         end else begin : g_zero
            assign status_word[g] = `CDR_BIT_LOW;
         end
      end
   endgenerate

   //------------------------------------------------------------
   // read mux
   //------------------------------------------------------------
   always @* begin
      rdata_d = `CDR_ZERO16;
      case (reg_addr)
         `CDR_OFS_INT_FRAC_HI: begin
            rdata_d = int_frac_hi_q;
         end
         `CDR_OFS_FRAC_LO: begin
            rdata_d = frac_lo_q;
         end
         `CDR_OFS_STATUS: begin
            rdata_d = status_word;
         end
         default: begin
            // unmapped offsets read as zero
            rdata_d = `CDR_ZERO16;
         end
      endcase
   end

   //------------------------------------------------------------
   // read response next values
   //------------------------------------------------------------
   // data holds between reads so a late sample still sees it
   always @* begin
      rvalid_d     = reg_rd;
      rdata_hold_d = reg_rdata;
      if (reg_rd) begin
         rdata_hold_d = rdata_d;
      end
   end

   //------------------------------------------------------------
   // divider and pin next values
   //------------------------------------------------------------
   always @* begin
      // zero field still divides by one
      divide_ratio_d     = {1'h0, ch7_integer_divider} + `CDR_ONE9;
      fraction_setting_d = {frac_high_nibble, frac_lo_q};
      // setting stays visible; the enable alone gates its use
      fraction_active_d  = ch7_fraction_enable;
      // pin polarity is the inverse of the status bit
      lock_pin_d         = ~stat_sync[`CDR_STAT_UNLOCK];
   end

   //------------------------------------------------------------
   // read response flops
   //------------------------------------------------------------
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata  <= `CDR_ZERO16;
         reg_rvalid <= `CDR_BIT_LOW;
      end else begin
         reg_rdata  <= rdata_hold_d;
         reg_rvalid <= rvalid_d;
      end
   end

   //------------------------------------------------------------
   // divider flops
   //------------------------------------------------------------
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ch7_divide_ratio     <= `CDR_ONE9;
         ch7_fraction_setting <= `CDR_ZERO20;
      end else begin
         ch7_divide_ratio     <= divide_ratio_d;
         ch7_fraction_setting <= fraction_setting_d;
      end
   end

   //------------------------------------------------------------
   // lock pin and fraction enable flops
   //------------------------------------------------------------
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ch7_fraction_active <= `CDR_BIT_LOW;
         lock_pin            <= `CDR_BIT_LOW;
      end else begin
         ch7_fraction_active <= fraction_active_d;
         lock_pin            <= lock_pin_d;
      end
   end

endmodule

// ===== tb/cdr_chk.sv
// assertions on the ch7 register slice ports
`timescale 1ns/1ps
module cdr_chk (
   input wire        clock,
   input wire        arst_n,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [5:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        ch7_fraction_enable,
   input wire        pll_unlocked,
   input wire        reference_lost_flag,
   input wire        ref_secondary,
   input wire [15:0] reg_rdata,
   input wire        reg_rvalid,
   input wire [8:0]  ch7_divide_ratio,
   input wire [19:0] ch7_fraction_setting,
   input wire        ch7_fraction_active,
   input wire        lock_pin
);
default clocking @(posedge clock); endclocking
default disable iff (!arst_n);
wire       w13    = reg_wr && reg_addr == 6'h13;
wire       rs     = reg_rd && reg_addr == 6'h15;
wire [2:0] st     = {pll_unlocked, reference_lost_flag, ref_secondary};
// named slices keep the history functions on plain signals
wire [7:0] wd_int = reg_wdata[11:4];
wire [3:0] wd_hi  = reg_wdata[3:0];
read_pulse_a: assert property(reg_rvalid == $past(reg_rd)) else $error("rv");
div_ratio_a: assert property(w13 |-> ##2
   ch7_divide_ratio == {1'h0, $past(wd_int, 2)} + 9'h001)
   else $error("ratio");
frac_high_a: assert property(w13 |-> ##2
   ch7_fraction_setting[19:16] == $past(wd_hi, 2)) else $error("hi");
frac_low_a: assert property(reg_wr && reg_addr == 6'h14 |-> ##2
   ch7_fraction_setting[15:0] == $past(reg_wdata, 2)) else $error("lo");
status_zero_a: assert property(rs |=> reg_rdata[15:3] == 0)
   else $error("zero");
status_bits_a: assert property($stable(st)[*4] ##0 rs |=>
   reg_rdata[2:0] == $past(st)) else $error("bits");
// pin needs three clean edges after reset before it follows the input
lock_pin_a: assert property($stable(pll_unlocked)[*5] ##0 $past(arst_n, 3) |->
   lock_pin != pll_unlocked) else $error("lock");
frac_on_a: assert property($stable(ch7_fraction_enable)[*2] |->
   ch7_fraction_active == ch7_fraction_enable) else $error("en");
rdata_hold_a: assert property(!reg_rd |=> $stable(reg_rdata))
   else $error("hold");
cover property(w13);
cover property(rs);
cover property($fell(lock_pin));
endmodule
bind cdr_ch7_regs cdr_chk i_cdr_chk (
   .clock                (clock),
   .arst_n               (arst_n),
   .reg_wr               (reg_wr),
   .reg_rd               (reg_rd),
   .reg_addr             (reg_addr),
   .reg_wdata            (reg_wdata),
   .ch7_fraction_enable  (ch7_fraction_enable),
   .pll_unlocked         (pll_unlocked),
   .reference_lost_flag  (reference_lost_flag),
   .ref_secondary        (ref_secondary),
   .reg_rdata            (reg_rdata),
   .reg_rvalid           (reg_rvalid),
   .ch7_divide_ratio     (ch7_divide_ratio),
   .ch7_fraction_setting (ch7_fraction_setting),
   .ch7_fraction_active  (ch7_fraction_active),
   .lock_pin             (lock_pin)
);

// ===== tb/cdr_host.sv
// host model driving the register strobes of the ch7 slice
`timescale 1ns/1ps
module cdr_host (
   input  wire         clock,
   input  wire  [15:0] reg_rdata,
   input  wire         reg_rvalid,
   output logic        reg_wr = 1'h0,
   output logic        reg_rd = 1'h0,
   output logic [5:0]  reg_addr = 6'h00,
   output logic [15:0] reg_wdata = 16'h0000
);
task wr(input [5:0] a, input [15:0] d);
   @(posedge clock);
   reg_wr    <= 1'h1;
   reg_addr  <= a;
   // only the integer register wants its top nibble cleared
   reg_wdata <= (a == 6'h13) ? {4'h0, d[11:0]} : d;
   @(posedge clock);
   reg_wr    <= 1'h0;
   // released data flips so a stale sample never looks valid
   reg_wdata <= ~reg_wdata;
endtask
task rd(input [5:0] a, output [15:0] d);
   @(posedge clock);
   reg_rd   <= 1'h1;
   reg_addr <= a;
   @(posedge clock);
   reg_rd   <= 1'h0;
   @(posedge clock);
   // a missing valid pulse poisons the returned word
   d = reg_rvalid ? reg_rdata : 16'hXXXX;
endtask
endmodule

// ===== tb/cdr_ch7_regs_bench.sv
// self-checking bench for the ch7 register slice
`timescale 1ns/1ps
module cdr_ch7_regs_bench;
logic clock=0,arst_n=0,ch7_fraction_enable=0,pll_unlocked=0;
logic reference_lost_flag=0,ref_secondary=0,reg_rvalid,ch7_fraction_active;
logic lock_pin; logic [15:0] reg_rdata,d; logic [8:0] ch7_divide_ratio;
logic [19:0] ch7_fraction_setting; wire reg_wr,reg_rd; wire [5:0] reg_addr;
wire [15:0] reg_wdata; int n_errors=0,num_checks=0,cyc=0;
logic [15:0] v[3] = '{16'h0FFF, 16'h0000, 16'h0AB5};
`define CHK(a,e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("wrong value at %0t: %h", $time, a); end end
cdr_ch7_regs i_cdr_ch7_regs (
   .clock                (clock),
   .arst_n               (arst_n),
   .reg_wr               (reg_wr),
   .reg_rd               (reg_rd),
   .reg_addr             (reg_addr),
   .reg_wdata            (reg_wdata),
   .ch7_fraction_enable  (ch7_fraction_enable),
   .pll_unlocked         (pll_unlocked),
   .reference_lost_flag  (reference_lost_flag),
   .ref_secondary        (ref_secondary),
   .reg_rdata            (reg_rdata),
   .reg_rvalid           (reg_rvalid),
   .ch7_divide_ratio     (ch7_divide_ratio),
   .ch7_fraction_setting (ch7_fraction_setting),
   .ch7_fraction_active  (ch7_fraction_active),
   .lock_pin             (lock_pin)
);
cdr_host i_cdr_host (
   .clock      (clock),
   .reg_rdata  (reg_rdata),
   .reg_rvalid (reg_rvalid),
   .reg_wr     (reg_wr),
   .reg_rd     (reg_rd),
   .reg_addr   (reg_addr),
   .reg_wdata  (reg_wdata)
);
initial forever #25 clock = ~clock;
always @(posedge clock) if (++cyc > 3000) begin n_errors++; summarize; end
task summarize;
   $display("checks %0d errors %0d", num_checks, n_errors);
   if (n_errors == 0 && num_checks > 0) $display("Regression OK");
   else $display("Regression broken");
   $finish;
endtask
initial begin
   repeat (10) @(posedge clock); arst_n <= 1; repeat (4) @(posedge clock);
   i_cdr_host.rd(6'h13, d); `CHK(d, 16'h0000)
   `CHK(ch7_divide_ratio, 9'h001)
   foreach (v[k]) begin
      i_cdr_host.wr(6'h13, v[k]); i_cdr_host.rd(6'h13, d); `CHK(d, v[k])
      `CHK(ch7_divide_ratio, {1'b0, v[k][11:4]} + 9'h001)
      `CHK(ch7_fraction_setting[19:16], v[k][3:0])
   end
   i_cdr_host.wr(6'h14, 16'hBEEF); i_cdr_host.wr(6'h15, 16'hFFFF);
   i_cdr_host.rd(6'h14, d); `CHK(d, 16'hBEEF)
   `CHK(ch7_fraction_setting, 20'h5BEEF)
   i_cdr_host.rd(6'h13, d); `CHK(d, 16'h0AB5)
   for (int i = 0; i < 8; i++) begin
      {pll_unlocked, reference_lost_flag, ref_secondary} <= i[2:0];
      ch7_fraction_enable <= i[0]; repeat (4) @(posedge clock);
      repeat (2) begin i_cdr_host.rd(6'h15, d); `CHK(d, {13'h0, i[2:0]}) end
      `CHK(lock_pin, ~i[2])
      `CHK(ch7_fraction_active, i[0])
   end
   i_cdr_host.rd(6'h16, d); `CHK(d, 16'h0000)
   summarize;
end
endmodule
